// ### bchr_pkg.sv
`default_nettype none
// ==========================================================================
// Constants and carriers for the configuration header
package bchr_pkg;

   // =======================================================================
   // Register word byte addresses
   localparam logic [7:0] OFS_CLASS_REV = 8'h08;
   localparam logic [7:0] OFS_CACHE_HDR = 8'h0c;
   localparam logic [7:0] OFS_BUS_NUM   = 8'h18;
   localparam logic [7:0] OFS_IO_BASE   = 8'h1c;

   // =======================================================================
   // Byte lane of each field
   localparam int LANE_REV      = 0;
   localparam int LANE_PROGIF   = 1;
   localparam int LANE_SUBCLASS = 2;
   localparam int LANE_BASECLS  = 3;
   localparam int LANE_CLS      = 0;
   localparam int LANE_PRILAT   = 1;
   localparam int LANE_HDR      = 2;
   localparam int LANE_PRIBUS   = 0;
   localparam int LANE_SECBUS   = 1;
   localparam int LANE_SUBBUS   = 2;
   localparam int LANE_SECLAT   = 3;
   localparam int LANE_IOBASE   = 0;

   // =======================================================================
   // Constant field values
   localparam logic [7:0] REV_ID_DEF    = 8'h3a;  // Arbitrary value
   localparam logic [7:0] PROGIF_VAL    = 8'h00;
   localparam logic [7:0] SUBCLASS_VAL  = 8'h04;
   localparam logic [7:0] BASECLASS_VAL = 8'h06;
   localparam logic [7:0] HDR_TYPE_VAL  = 8'h01;
   localparam logic [3:0] IO_CAP_VAL    = 4'h1;
   localparam logic [7:0] CLS_MAX       = 8'h10;
   localparam logic [7:0] PREFETCH_MIN  = 8'h01;
   localparam logic [11:0] IO_LOW_BASE  = 12'h000;
   localparam logic [11:0] IO_LOW_TOP   = 12'hfff;

   // =======================================================================
   // Reset values of writable fields
   localparam logic [7:0] CLS_RST    = 8'h00;
   localparam logic [7:0] LAT_RST    = 8'h00;
   localparam logic [7:0] BUS_RST    = 8'h00;
   localparam logic [3:0] IOBASE_RST = 4'h0;

   // =======================================================================
   // Master status of one bus interface
   typedef struct packed {
      logic       frameStart;   // Pulse: our FRAME# just asserted
      logic       frameActive;  // Level: we own the bus as master
      logic       gnt;          // Level: grant still present
      logic       mwi;          // Level: burst is memory write and invalidate
      logic       dataPhase;    // Pulse: one data phase completed
      logic [4:0] startDword;   // Dword index of the burst start address
   } bchr_mst_s;

   // Decisions back to that master
   typedef struct packed {
      logic stopReq;       // End the burst after this data phase
      logic timerExpired;  // Latency timer has run out
      logic lineEnd;       // MWI burst and this data phase closes a cache line
   } bchr_mctl_s;

   // Configuration snapshot for forwarding decode
   typedef struct packed {
      logic [7:0] priBus;
      logic [7:0] secBus;
      logic [7:0] subBus;
      logic [7:0] cacheLine;
      logic [7:0] priLat;
      logic [7:0] secLat;
      logic [3:0] ioBase4;
   } bchr_cfg_s;

endpackage
`default_nettype wire

// ### bchr_lat_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Master latency timer
module bchr_lat_timer (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Control
   input  wire logic       start,
   input  wire logic       active,
   input  wire logic [7:0] loadValue,
   // Status
   output logic            expired
);

   logic [7:0] count_r;

   // Reload at frame start, count down while we own the bus
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_r <= 8'h00;
      end else if (start) begin
         count_r <= loadValue;
      end else if (active && (count_r != 8'h00)) begin
         count_r <= count_r - 8'h01;
      end
   end

   // Zero load means expired from the clock after the frame start pulse
   assign expired = active && !start && (count_r == 8'h00);

endmodule
`default_nettype wire

// ### bchr_io_window.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// I/O forwarding window compare
module bchr_io_window
   import bchr_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // Window
   input  wire logic [15:0] baseUpper,
   input  wire logic [3:0]  base4,
   input  wire logic [15:0] limitUpper,
   input  wire logic [3:0]  limit4,
   // Transaction
   input  wire logic        ioValid,
   input  wire logic [31:0] ioAddr,
   // Result
   output logic             hit
);

   logic [31:0] bottom;
   logic [31:0] top;

   // Base low bits read as zero, top low bits as all ones
   assign bottom = {baseUpper, base4, IO_LOW_BASE};
   assign top    = {limitUpper, limit4, IO_LOW_TOP};

   // Registered so the forwarding decode sees a clean flop output
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hit <= 1'b0;
      end else begin
         hit <= ioValid && (ioAddr >= bottom) && (ioAddr <= top);
      end
   end

endmodule
`default_nettype wire

// ### bchr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Revision byte at 08h is constant.
// - Class bytes read 00h, 04h, 06h.
// - Cache line size ends MWI bursts and sizes read prefetch.
// - Primary latency timer, 0Ch 15:8, counts from FRAME#.
// - Header type at 0Ch bits 23:16 reads constant 01h.
// - Primary bus number, 18h 7:0, RW.
// - Secondary bus number, 18h 15:8, RW.
// - Subordinate bus number, 18h 23:16, RW.
// - Secondary latency timer at 18h bits 31:24 counts from S_FRAME#.
// - Secondary timer zero, grant gone: stop after first data phase, except MWI.
// - I/O base bits 3:0 read constant 1 for 32-bit I/O.
// - I/O base bits 7:4 give address 15:12; low twelve bits zero.
// - I/O base address 31:16 comes from the separate upper register.
// - I/O window top low twelve bits are all ones.
// ==========================================================================
// Bridge configuration header, offsets 08h to 1Ch, APB slave
module bchr_regs
   import bchr_pkg::*;
#(
   parameter logic [7:0] REV_ID = REV_ID_DEF  // Arbitrary value
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Master status
   input  wire bchr_pkg::bchr_mst_s priMst,
   input  wire bchr_pkg::bchr_mst_s secMst,
   // Master decisions
   output bchr_pkg::bchr_mctl_s     priCtl,
   output bchr_pkg::bchr_mctl_s     secCtl,
   // I/O window pieces held elsewhere
   input  wire logic [15:0] ioBaseUpper,
   input  wire logic [15:0] ioLimitUpper,
   input  wire logic [3:0]  ioLimit4,
   // I/O forwarding decode
   input  wire logic        ioValid,
   input  wire logic [31:0] ioAddr,
   output logic             ioForward,
   // Configuration to forwarding and prefetch logic
   output bchr_pkg::bchr_cfg_s      cfgOut,
   output logic [7:0]       prefetchDwords
);

   // =======================================================================
   // Register state
   logic [7:0] cacheLine_r;
   logic [7:0] priLat_r;
   logic [7:0] priBus_r;
   logic [7:0] secBus_r;
   logic [7:0] subBus_r;
   logic [7:0] secLat_r;
   logic [3:0] ioBase4_r;
   logic [7:0] prefetch_r;
   logic [31:0] prdata_r;
   logic [31:0] rdWord;

   // =======================================================================
   // Bus decode
   logic setup;
   logic access;
   logic hitClassRev;
   logic hitCacheHdr;
   logic hitBusNum;
   logic hitIoBase;
   logic mapped;
   logic wrCacheHdr;
   logic wrBusNum;
   logic wrIoBase;

   // Bits 1:0 ignored; one aligned word per register
   assign hitClassRev = (paddr[7:2] == OFS_CLASS_REV[7:2]);
   assign hitCacheHdr = (paddr[7:2] == OFS_CACHE_HDR[7:2]);
   assign hitBusNum   = (paddr[7:2] == OFS_BUS_NUM[7:2]);
   assign hitIoBase   = (paddr[7:2] == OFS_IO_BASE[7:2]);
   assign mapped      = hitClassRev || hitCacheHdr || hitBusNum || hitIoBase;

   // Zero-wait slave
   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign pready  = access;
   assign pslverr = access && !mapped;

   // Write strobes; the 08h word has no writable lane
   assign wrCacheHdr = access && pwrite && hitCacheHdr;
   assign wrBusNum   = access && pwrite && hitBusNum;
   assign wrIoBase   = access && pwrite && hitIoBase;

   // =======================================================================
   // Writable fields

   // Cache line size, stored as written
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cacheLine_r <= CLS_RST;
      end else if (wrCacheHdr && pstrb[LANE_CLS]) begin
         cacheLine_r <= pwdata[LANE_CLS*8 +: 8];
      end
   end

   // Primary latency timer value
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         priLat_r <= LAT_RST;
      end else if (wrCacheHdr && pstrb[LANE_PRILAT]) begin
         priLat_r <= pwdata[LANE_PRILAT*8 +: 8];
      end
   end

   // Primary bus number
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         priBus_r <= BUS_RST;
      end else if (wrBusNum && pstrb[LANE_PRIBUS]) begin
         priBus_r <= pwdata[LANE_PRIBUS*8 +: 8];
      end
   end

   // Secondary bus number
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         secBus_r <= BUS_RST;
      end else if (wrBusNum && pstrb[LANE_SECBUS]) begin
         secBus_r <= pwdata[LANE_SECBUS*8 +: 8];
      end
   end

   // Subordinate bus number
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         subBus_r <= BUS_RST;
      end else if (wrBusNum && pstrb[LANE_SUBBUS]) begin
         subBus_r <= pwdata[LANE_SUBBUS*8 +: 8];
      end
   end

   // Secondary latency timer value
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         secLat_r <= LAT_RST;
      end else if (wrBusNum && pstrb[LANE_SECLAT]) begin
         secLat_r <= pwdata[LANE_SECLAT*8 +: 8];
      end
   end

   // I/O base: upper nibble writable only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ioBase4_r <= IOBASE_RST;
      end else if (wrIoBase && pstrb[LANE_IOBASE]) begin
         ioBase4_r <= pwdata[LANE_IOBASE*8+4 +: 4];
      end
   end

   // =======================================================================
   // Read path

   // Constant fields never come from storage
   always_comb begin
      rdWord = 32'h0000_0000;
      if (hitClassRev) begin
         rdWord[LANE_REV*8 +: 8]      = REV_ID;
         rdWord[LANE_PROGIF*8 +: 8]   = PROGIF_VAL;
         rdWord[LANE_SUBCLASS*8 +: 8] = SUBCLASS_VAL;
         rdWord[LANE_BASECLS*8 +: 8]  = BASECLASS_VAL;
      end else if (hitCacheHdr) begin
         rdWord[LANE_CLS*8 +: 8]      = cacheLine_r;
         rdWord[LANE_PRILAT*8 +: 8]   = priLat_r;
         rdWord[LANE_HDR*8 +: 8]      = HDR_TYPE_VAL;
      end else if (hitBusNum) begin
         rdWord[LANE_PRIBUS*8 +: 8]   = priBus_r;
         rdWord[LANE_SECBUS*8 +: 8]   = secBus_r;
         rdWord[LANE_SUBBUS*8 +: 8]   = subBus_r;
         rdWord[LANE_SECLAT*8 +: 8]   = secLat_r;
      end else if (hitIoBase) begin
         rdWord[LANE_IOBASE*8 +: 4]   = IO_CAP_VAL;
         rdWord[LANE_IOBASE*8+4 +: 4] = ioBase4_r;
      end
   end

   // Captured in setup so prdata is a flop in the access phase
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_r <= rdWord;
      end
   end

   assign prdata = prdata_r;

   // =======================================================================
   // Cache line use

   logic       clsValid;
   logic [7:0] clsEff;
   logic [4:0] clsMask;

   // Invalid sizes act as no cache line, not a bogus length
   assign clsValid = ((cacheLine_r & (cacheLine_r - 8'h01)) == 8'h00) &&
                     (cacheLine_r <= CLS_MAX);
   assign clsEff   = clsValid ? cacheLine_r : 8'h00;
   assign clsMask  = clsEff[4:0] - 5'h01;

   // Prefetch at least one dword even with no line programmed
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prefetch_r <= PREFETCH_MIN;
      end else if (clsEff == 8'h00) begin
         prefetch_r <= PREFETCH_MIN;
      end else begin
         prefetch_r <= clsEff;
      end
   end

   assign prefetchDwords = prefetch_r;

   // =======================================================================
   // Latency timer and burst end per interface, 0 primary

   bchr_mst_s  mst [2];
   bchr_mctl_s ctl [2];
   logic [7:0] latVal [2];

   assign mst[0]    = priMst;
   assign mst[1]    = secMst;
   assign latVal[0] = priLat_r;
   assign latVal[1] = secLat_r;
   assign priCtl    = ctl[0];
   assign secCtl    = ctl[1];

   for (genvar g = 0; g < 2; g++) begin : gIf
      logic       expired;
      logic [4:0] dwordPos_r;
      logic [4:0] nextPos;
      logic       atLineEnd;

      // Timer loads on our FRAME#
      bchr_lat_timer uTimer (
         .mclk      (mclk),
         .resetn    (resetn),
         .start     (mst[g].frameStart),
         .active    (mst[g].frameActive),
         .loadValue (latVal[g]),
         .expired   (expired)
      );

      // Dword position inside the cache line
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            dwordPos_r <= 5'h00;
         end else if (mst[g].frameStart) begin
            dwordPos_r <= mst[g].startDword;
         end else if (mst[g].dataPhase) begin
            dwordPos_r <= nextPos;
         end
      end

      // With no valid line every dword closes a line, which keeps MWI legal
      assign nextPos   = dwordPos_r + 5'h01;
      assign atLineEnd = (clsEff == 8'h00) || ((nextPos & clsMask) == 5'h00);

      // MWI ends only on a line boundary; other bursts end once expired with the grant gone
      always_comb begin
         ctl[g].timerExpired = expired;
         ctl[g].lineEnd      = mst[g].mwi && atLineEnd;
         ctl[g].stopReq      = 1'b0;
         if (mst[g].frameActive && mst[g].dataPhase && expired && !mst[g].gnt) begin
            if (!mst[g].mwi) begin
               ctl[g].stopReq = 1'b1;
            end else if (atLineEnd) begin
               ctl[g].stopReq = 1'b1;
            end
         end
      end
   end

   // =======================================================================
   // I/O forwarding decode

   bchr_io_window uIoWin (
      .mclk       (mclk),
      .resetn     (resetn),
      .baseUpper  (ioBaseUpper),
      .base4      (ioBase4_r),
      .limitUpper (ioLimitUpper),
      .limit4     (ioLimit4),
      .ioValid    (ioValid),
      .ioAddr     (ioAddr),
      .hit        (ioForward)
   );

   // =======================================================================
   // Configuration snapshot, straight from flops
   assign cfgOut.priBus    = priBus_r;
   assign cfgOut.secBus    = secBus_r;
   assign cfgOut.subBus    = subBus_r;
   assign cfgOut.cacheLine = cacheLine_r;
   assign cfgOut.priLat    = priLat_r;
   assign cfgOut.secLat    = secLat_r;
   assign cfgOut.ioBase4   = ioBase4_r;

endmodule
`default_nettype wire

// ### bchr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker for the header block
module bchr_regs_chk
   import bchr_pkg::*;
#(
   parameter logic [7:0] REV_ID = REV_ID_DEF  // Arbitrary value
) (
   // Clock and reset
   input wire logic                mclk,
   input wire logic                resetn,
   // APB
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [3:0]          pstrb,
   input wire logic [31:0]         prdata,
   // Master side
   input wire bchr_pkg::bchr_mst_s  priMst,
   input wire bchr_pkg::bchr_mst_s  secMst,
   input wire bchr_pkg::bchr_mctl_s priCtl,
   input wire bchr_pkg::bchr_mctl_s secCtl,
   // Configuration
   input wire bchr_pkg::bchr_cfg_s  cfgOut
);
   logic       rdSetup;
   logic       wrAcc;
   logic [7:0] priCnt_r;
   logic [7:0] secCnt_r;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // ==========
   // Helpers
   assign rdSetup = psel && !penable && !pwrite;
   assign wrAcc   = psel && penable && pwrite;

   // Cycles since our FRAME#; saturates so it never wraps
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         priCnt_r <= 8'h00;
         secCnt_r <= 8'h00;
      end else begin
         priCnt_r <= priMst.frameStart ? 8'h01 : priCnt_r + {7'h00, priCnt_r != 8'hff};
         secCnt_r <= secMst.frameStart ? 8'h01 : secCnt_r + {7'h00, secCnt_r != 8'hff};
      end
   end

   // ==========
   // Assertions
   class_rd_a:
      assert property (rdSetup && paddr[7:2] == 6'h02 |=> prdata == {24'h060400, REV_ID})
      else $error("class word wrong");
   hdr_rd_a:
      assert property (rdSetup && paddr[7:2] == 6'h03 |=> prdata[31:16] == 16'h0001)
      else $error("header type byte wrong");
   io_ind_rd_a:
      assert property (rdSetup && paddr[7:2] == 6'h07 |=> prdata[3:0] == 4'h1)
      else $error("io indicator wrong");
   bus_wr_a:
      assert property (wrAcc && paddr[7:2] == 6'h06 && pstrb == 4'hf
         |=> {cfgOut.secLat, cfgOut.subBus, cfgOut.secBus, cfgOut.priBus} == $past(pwdata))
      else $error("bus word not stored");
   cls_wr_a:
      assert property (wrAcc && paddr[7:2] == 6'h03 && pstrb[0]
         |=> cfgOut.cacheLine == $past(pwdata[7:0]))
      else $error("cache line size not stored");
   pri_early_a:
      assert property (priMst.frameActive && !priMst.frameStart && priCnt_r < cfgOut.priLat
         |-> !priCtl.timerExpired)
      else $error("primary timer expired early");
   sec_early_a:
      assert property (secMst.frameActive && !secMst.frameStart && secCnt_r < cfgOut.secLat
         |-> !secCtl.timerExpired)
      else $error("secondary timer expired early");
   lat_zero_a:
      assert property (secMst.frameStart && cfgOut.secLat == 8'h00 ##1 secMst.frameActive
         |-> secCtl.timerExpired)
      else $error("zero timer not expired");
   stop_req_a:
      assert property (secMst.frameActive && secMst.dataPhase && secCtl.timerExpired
         && !secMst.gnt && !secMst.mwi |-> secCtl.stopReq)
      else $error("burst not stopped");
   gnt_hold_a:
      assert property (secMst.gnt |-> !secCtl.stopReq)
      else $error("stop while grant held");
endmodule

bind bchr_regs bchr_regs_chk #(.REV_ID(REV_ID)) u_bchr_regs_chk (.*);
`default_nettype wire

// ### bchr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus master stand-in: one burst per start pulse
module bchr_master_model
   import bchr_pkg::*;
(
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 resetn,
   // Burst request
   input  wire logic                 start,
   input  wire logic [4:0]           len,
   input  wire logic [1:0]           waitCycles,
   input  wire logic                 gnt,
   input  wire logic                 mwi,
   input  wire logic [4:0]           startDword,
   // Decisions from the block
   input  wire bchr_pkg::bchr_mctl_s ctl,
   // Status to the block
   output bchr_pkg::bchr_mst_s       mst,
   output logic                      done,
   output logic [4:0]                phases
);
   logic       busy_r;
   logic [1:0] waitCnt_r;

   // Ends at its length or when the block asks to stop
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busy_r    <= 1'b0;
         waitCnt_r <= 2'b00;
         mst       <= '0;
         done      <= 1'b0;
         phases    <= 5'h00;
      end else begin
         mst.frameStart <= 1'b0;
         mst.dataPhase  <= 1'b0;
         mst.gnt        <= gnt;
         done           <= 1'b0;
         if (start && !busy_r) begin
            busy_r          <= 1'b1;
            mst.frameStart  <= 1'b1;
            mst.frameActive <= 1'b1;
            mst.mwi         <= mwi;
            mst.startDword  <= startDword;
            phases          <= 5'h00;
            waitCnt_r       <= waitCycles;
         end else if (busy_r) begin
            if (mst.dataPhase && (ctl.stopReq || phases == len)) begin
               busy_r          <= 1'b0;
               mst.frameActive <= 1'b0;
               mst.mwi         <= ~mst.mwi;  // Stale qualifiers must not look valid
               mst.startDword  <= ~mst.startDword;
               done            <= 1'b1;
            end else if (waitCnt_r != 2'b00) begin
               waitCnt_r <= waitCnt_r - 2'b01;
            end else begin
               mst.dataPhase <= 1'b1;
               phases        <= phases + 5'h01;
               waitCnt_r     <= waitCycles;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench for the configuration header block
module tb;
   import bchr_pkg::*;
   localparam logic [7:0] REV = 8'h5c;  // Arbitrary value
   logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, er, hitExp;
   logic        ioValid, ioForward, priGo, secGo, fGnt, fMwi, priDone, secDone;
   logic [7:0]  paddr, prefetchDwords, sCls, sPriLat, ra;
   logic [31:0] pwdata, prdata, ioAddr, sBus, rd, rw;
   logic [3:0]  pstrb, ioLimit4, sIo4, rs;
   logic [15:0] ioBaseUpper, ioLimitUpper;
   logic [4:0]  fLen, fSd, priPh, secPh;
   logic [1:0]  fWait;
   bchr_mst_s   priMst, secMst;
   bchr_mctl_s  priCtl, secCtl;
   bchr_cfg_s   cfgOut;
   int          errors, testsRun, seed, i;

   // ==========
   // Clock, design and two master stand-ins
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   bchr_regs #(.REV_ID(REV)) u_bchr_regs (.*);
   bchr_master_model u_pri (.mclk(mclk), .resetn(resetn), .start(priGo), .len(fLen),
      .waitCycles(fWait), .gnt(fGnt), .mwi(fMwi), .startDword(fSd), .ctl(priCtl),
      .mst(priMst), .done(priDone), .phases(priPh));
   bchr_master_model u_sec (.mclk(mclk), .resetn(resetn), .start(secGo), .len(fLen),
      .waitCycles(fWait), .gnt(fGnt), .mwi(fMwi), .startDword(fSd), .ctl(secCtl),
      .mst(secMst), .done(secDone), .phases(secPh));

   // ==========
   // Reporting
   task automatic summarize();
      if (errors == 0 && testsRun > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ==========
   // APB master: setup, access until pready, release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         errors++;
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   // ==========
   // Expected register image
   function automatic logic [31:0] exp_word(input logic [5:0] w);
      case (w)
         6'h02:   return {24'h060400, REV};
         6'h03:   return {16'h0001, sPriLat, sCls};
         6'h06:   return sBus;
         6'h07:   return {24'h0, sIo4, 4'h1};
         default: return 32'h0;
      endcase
   endfunction

   // Write and mirror the writable lanes only
   task automatic setw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      apb(1'b1, a, d, s);
      chk(64'(er), 64'(!(a[7:2] inside {6'h02, 6'h03, 6'h06, 6'h07})));
      if (a[7:2] == 6'h03 && s[0]) sCls = d[7:0];
      if (a[7:2] == 6'h03 && s[1]) sPriLat = d[15:8];
      if (a[7:2] == 6'h07 && s[0]) sIo4 = d[7:4];
      for (int k = 0; k < 4; k++)
         if (a[7:2] == 6'h06 && s[k]) sBus[k*8 +: 8] = d[k*8 +: 8];
   endtask

   // Read the whole space
   task automatic check_all();
      for (int k = 0; k < 64; k++) begin
         apb(1'b0, {k[5:0], 2'b00}, 32'h0, 4'h0);
         chk(64'(rd), 64'(exp_word(k[5:0])));
         chk(64'(er), 64'(!(k inside {2, 3, 6, 7})));
      end
      chk(64'(cfgOut), 64'({sBus[7:0], sBus[15:8], sBus[23:16], sCls, sPriLat,
          sBus[31:24], sIo4}));
      chk(64'(prefetchDwords), 64'((sCls inside {1, 2, 4, 8, 16}) ? sCls : 8'h01));
   endtask

   // One burst; checks its data phase count
   task automatic run_frame(input logic sec, input logic [4:0] len, input logic [1:0] wt,
                            input logic g, input logic m, input logic [4:0] sd,
                            input logic [4:0] expPh);
      int n;
      n = 0;
      fLen  <= len;
      fWait <= wt;
      fGnt  <= g;
      fMwi  <= m;
      fSd   <= sd;
      priGo <= !sec;
      secGo <= sec;
      @(posedge mclk);
      priGo <= 1'b0;
      secGo <= 1'b0;
      while ((sec ? secDone : priDone) !== 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 200) begin
         errors++;
         summarize();
      end
      chk(64'(sec ? secPh : priPh), 64'(expPh));
      @(posedge mclk);
   endtask

   // Registered window hit, seen one cycle after the address
   task automatic io_chk(input logic [31:0] a);
      ioValid <= 1'b1;
      ioAddr  <= a;
      @(posedge mclk);
      hitExp = a >= {ioBaseUpper, sIo4, 12'h000} && a <= {ioLimitUpper, ioLimit4, 12'hfff};
      ioValid <= 1'b0;
      @(posedge mclk);
      chk(64'(ioForward), 64'(hitExp));
   endtask

   // ==========
   // Main sequence
   initial begin
      seed = 89654;
      errors = 0;
      testsRun = 0;
      {resetn, psel, penable, pwrite, ioValid, priGo, secGo, fGnt, fMwi} = '0;
      {paddr, pwdata, pstrb, ioAddr, ioBaseUpper, ioLimitUpper, ioLimit4} = '0;
      {fLen, fSd, fWait, sCls, sPriLat, sBus, sIo4} = '0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      check_all();
      // All ones except 10h in the low byte; constant fields must not move
      for (i = 0; i < 64; i++)
         setw({i[5:0], 2'b00}, 32'hffffff10, 4'hf);
      check_all();
      // Random writes, half to mapped words
      for (i = 0; i < 40; i++) begin
         rw = $random(seed);
         ra = $random(seed);
         rs = $random(seed);
         if (!i[0]) ra[7:2] = {3'b000, ra[3], 1'b1, ra[2]};
         rw[7:0] = (rw[10:8] > 3'h4) ? 8'h00 : 8'h01 << rw[10:8];
         setw(ra, rw, rs);
         if (i % 10 == 9) check_all();
      end
      // Window edges with random upper halves
      for (i = 0; i < 6; i++) begin
         rw = $random(seed);
         ioBaseUpper  <= rw[15:0];
         ioLimitUpper <= rw[15:0] + {15'h0, rw[16]};
         ioLimit4     <= rw[23:20];
         setw(8'h1c, rw, 4'h1);
         io_chk({ioBaseUpper, sIo4, 12'h000});
         io_chk({ioBaseUpper, sIo4, 12'h000} - 32'h1);
         io_chk({ioLimitUpper, ioLimit4, 12'hfff});
         io_chk({ioLimitUpper, ioLimit4, 12'hfff} + 32'h1);
      end
      // Bursts: zero timer, line ends, grant kept, long timer, primary side
      setw(8'h0c, 32'h00001404, 4'h3);
      setw(8'h18, 32'h00000000, 4'h8);
      run_frame(1'b1, 5'd8, 2'd0, 1'b0, 1'b0, 5'd0, 5'd1);
      run_frame(1'b1, 5'd8, 2'd2, 1'b0, 1'b0, 5'd0, 5'd1);
      run_frame(1'b1, 5'd8, 2'd0, 1'b0, 1'b1, 5'd0, 5'd4);
      run_frame(1'b1, 5'd8, 2'd1, 1'b0, 1'b1, 5'd2, 5'd2);
      run_frame(1'b1, 5'd5, 2'd0, 1'b1, 1'b0, 5'd0, 5'd5);
      setw(8'h18, 32'h28000000, 4'h8);
      run_frame(1'b1, 5'd6, 2'd0, 1'b0, 1'b0, 5'd0, 5'd6);
      run_frame(1'b0, 5'd4, 2'd0, 1'b0, 1'b0, 5'd0, 5'd4);
      setw(8'h0c, 32'h00000000, 4'h2);
      run_frame(1'b0, 5'd4, 2'd0, 1'b0, 1'b0, 5'd0, 5'd1);
      check_all();
      summarize();
   end
endmodule
`default_nettype wire
